// File: core/adc_conversion_timing_control.sv
// Conversion timing, calibration and result handling for the 10-bit converter
`timescale 1ns/1ps
`include "adc_timing_regs.svh"
module adc_conversion_timing_control import adc_timing_pkg::*; (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire converter_control_type ctrl_i,
	input wire logic start_i,
	input wire core_result_type core_res_i,
	output logic busy_o,
	output logic sample_o,
	output logic decide_o,
	output logic bc_tick_o,
	output logic cal_busy_o,
	output logic done_o,
	output logic [15:0] result_o
);
	conv_state_type state_r;
	logic [7:0] div_cnt_r;
	logic [7:0] phase_cnt_r;
	logic [15:0] cal_cnt_r;
	logic [7:0] div_val;
	logic [7:0] smp_val;
	logic bc_tick;
	logic [9:0] code_held_r;
	logic below_r;
	logic above_r;
	converter_control_type ctrl_r;
	logic conv_start;
	logic window_end;
	logic load_end;

	// Out-of-range inputs override the raw code; below ground wins
	function automatic logic [`RES_BITS-1:0] clamp_code(input logic below, input logic above,
		input logic [`RES_BITS-1:0] raw);
		if (below) begin
			clamp_code = `RES_ZERO;
		end else if (above) begin
			clamp_code = `RES_FULL;
		end else begin
			clamp_code = raw;
		end
	endfunction

	function automatic logic [7:0] div_of(input logic [1:0] sel);
		case (sel)
			2'b00: div_of = `DIV_SEL_00;
			2'b01: div_of = `DIV_SEL_01;
			2'b10: div_of = `DIV_SEL_10;
			default: div_of = `DIV_SEL_11;
		endcase
	endfunction

	function automatic logic [7:0] smp_of(input logic [1:0] sel);
		case (sel)
			2'b00: smp_of = `SMP_SEL_00;
			2'b01: smp_of = `SMP_SEL_01;
			2'b10: smp_of = `SMP_SEL_10;
			default: smp_of = `SMP_SEL_11;
		endcase
	endfunction

	// Settings frozen per conversion so the span stays fixed
	assign div_val = div_of(ctrl_r.basic_clock_divider_select);
	assign smp_val = smp_of(ctrl_r.sample_time_select);
	assign bc_tick = (div_cnt_r == div_val - 8'h01);
	// Prescaler restarts with each conversion, so its phase never stretches the span
	assign conv_start = start_i && (state_r == ST_IDLE);
	// Last basic clock of the sample window
	assign window_end = (state_r == ST_SAMPLE) && bc_tick && (phase_cnt_r == smp_val - 8'h01);
	// Last CPU cycle of the result load
	assign load_end = (state_r == ST_LOAD) && (phase_cnt_r == `LOAD_CPU - 8'h01);

	// Basic clock prescaler; free running so calibration keeps counting when idle
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt_r <= 8'h00;
		end else if (clk_en_i) begin
			if (conv_start) begin
				div_cnt_r <= 8'h00;
			end else if (bc_tick || div_cnt_r >= div_val) begin
				div_cnt_r <= 8'h00;
			end else begin
				div_cnt_r <= div_cnt_r + 8'h01;
			end
		end
	end

	// Control settings: taken while idle only
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r <= '0;
		end else if (clk_en_i && state_r == ST_IDLE) begin
			ctrl_r <= ctrl_i;
		end
	end

	// Conversion sequencer
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= ST_IDLE;
			phase_cnt_r <= 8'h00;
		end else if (clk_en_i) begin
			case (state_r)
				ST_IDLE: begin
					if (start_i) begin
						state_r <= ST_SAMPLE;
						phase_cnt_r <= 8'h00;
					end
				end
				ST_SAMPLE: begin
					if (bc_tick) begin
						if (phase_cnt_r == smp_val - 8'h01) begin
							state_r <= ST_DECIDE;
							phase_cnt_r <= 8'h00;
						end else begin
							phase_cnt_r <= phase_cnt_r + 8'h01;
						end
					end
				end
				ST_DECIDE: begin
					if (bc_tick) begin
						if (phase_cnt_r == `DECIDE_BC - 8'h01) begin
							state_r <= ST_LOAD;
							phase_cnt_r <= 8'h00;
						end else begin
							phase_cnt_r <= phase_cnt_r + 8'h01;
						end
					end
				end
				ST_LOAD: begin
					if (phase_cnt_r == `LOAD_CPU - 8'h01) begin
						state_r <= ST_IDLE;
						phase_cnt_r <= 8'h00;
					end else begin
						phase_cnt_r <= phase_cnt_r + 8'h01;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					phase_cnt_r <= 8'h00;
				end
			endcase
		end
	end

	// Input captured at the sample window edge and held afterwards
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			code_held_r <= `RES_ZERO;
			below_r <= 1'b0;
			above_r <= 1'b0;
		end else if (clk_en_i && window_end) begin
			code_held_r <= core_res_i.code;
			below_r <= core_res_i.below_ground;
			above_r <= core_res_i.above_ref;
		end
	end

	// Result register load in last CPU cycle of the span
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			result_o <= 16'h0000;
			done_o <= 1'b0;
		end else if (clk_en_i) begin
			done_o <= 1'b0;
			if (load_end) begin
				done_o <= 1'b1;
				// Bit 10 flags whether calibration was still running; bits 15:11 load zero
				result_o[15:`RES_BITS] <= {5'h00, cal_busy_o};
				result_o[`RES_BITS-1:0] <= clamp_code(below_r, above_r, code_held_r);
			end
		end
	end

	// Calibration counts only idle basic clocks, so conversions add their time
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cal_cnt_r <= 16'h0000;
			cal_busy_o <= 1'b1;
		end else if (clk_en_i && cal_busy_o && bc_tick && state_r == ST_IDLE) begin
			if (cal_cnt_r == `CAL_BC - 16'h0001) begin
				cal_busy_o <= 1'b0;
			end else begin
				cal_cnt_r <= cal_cnt_r + 16'h0001;
			end
		end
	end

	// Phase outputs decoded straight from the state register
	always_comb begin
		busy_o = 1'b0;
		sample_o = 1'b0;
		decide_o = 1'b0;
		case (state_r)
			ST_SAMPLE: begin
				busy_o = 1'b1;
				sample_o = 1'b1;
			end
			ST_DECIDE: begin
				busy_o = 1'b1;
				decide_o = 1'b1;
			end
			ST_LOAD: begin
				busy_o = 1'b1;
			end
			default: begin
				busy_o = 1'b0;
			end
		endcase
	end

	// Tick hidden while frozen so counters outside see no phantom clock
	assign bc_tick_o = bc_tick && clk_en_i;
endmodule // adc_conversion_timing_control

// File: core/adc_timing_regs.svh
// Constants for the converter timing controller
`ifndef ADC_TIMING_REGS_SVH
`define ADC_TIMING_REGS_SVH
`define DIV_SEL_00 8'h04
`define DIV_SEL_01 8'h02
`define DIV_SEL_10 8'h10
`define DIV_SEL_11 8'h08
`define SMP_SEL_00 8'h08
`define SMP_SEL_01 8'h10
`define SMP_SEL_10 8'h20
`define SMP_SEL_11 8'h40
`define DECIDE_BC 8'h28
`define LOAD_CPU 8'h02
`define CAL_BC 16'h0d00
`define RES_BITS 10
`define RES_FULL 10'h3ff
`define RES_ZERO 10'h000
`endif

// File: core/adc_timing_pkg.sv
// Types for the converter timing controller
package adc_timing_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_DECIDE = 3'b010,
		ST_LOAD = 3'b011
	} conv_state_type;
	typedef struct packed {
		logic [1:0] basic_clock_divider_select;
		logic [1:0] sample_time_select;
	} converter_control_type;
	typedef struct packed {
		logic below_ground;
		logic above_ref;
		logic [9:0] code;
	} core_result_type;
endpackage

// File: testbench/adc_timing_props.sv
// Timing checks for the converter controller
`timescale 1ns/1ps
module adc_timing_props (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic start_i,
	input wire logic busy_o,
	input wire logic sample_o,
	input wire logic decide_o,
	input wire logic cal_busy_o,
	input wire logic done_o,
	input wire logic [15:0] result_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence load_s;
		##[1:2] done_o;
	endsequence
	AST_TOP: assert property (result_o[15:11] == 5'h00)
		else $error("upper bits");
	AST_DONE_IDLE: assert property (done_o |-> !busy_o)
		else $error("done busy");
	AST_DONE_ONE: assert property (done_o |=> !done_o)
		else $error("done long");
	AST_HOLD: assert property ($fell(sample_o) && busy_o |-> decide_o)
		else $error("no decide");
	AST_DECIDE: assert property ($rose(decide_o) |-> decide_o [*8])
		else $error("decide short");
	AST_LOAD: assert property ($fell(decide_o) |-> load_s)
		else $error("no load");
	AST_START: assert property (start_i && clk_en_i && !busy_o |=> busy_o && sample_o)
		else $error("no start");
	AST_CAL: assert property (!cal_busy_o |=> !cal_busy_o)
		else $error("cal again");
endmodule // adc_timing_props
bind adc_conversion_timing_control adc_timing_props u_props (.*);

// File: testbench/analog_core_model.sv
// Analog front end model
`timescale 1ns/1ps
module analog_core_model import adc_timing_pkg::*; (
	input wire logic [15:0] ain_i,
	output core_result_type res_o
);
	// Raw code left unclamped and always tracking
	assign res_o = {ain_i[15], !ain_i[15] && ain_i > 16'h03ff, ain_i[9:0]};
endmodule // analog_core_model

// File: testbench/test_adc_conversion_timing_control.sv
// Bench for the converter timing controller
`timescale 1ns/1ps
module test_adc_conversion_timing_control import adc_timing_pkg::*; ;
	typedef struct packed {logic [3:0] c; logic [15:0] a, b, e;} row_type;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, start_i = 1'b0, s;
	logic busy_o, sample_o, decide_o, bc_tick_o, cal_busy_o, done_o;
	logic [15:0] result_o, ain = 16'h0000;
	converter_control_type ctrl_i = 4'h4;
	core_result_type core_res_i;
	int mismatches = 0, checks = 0, cyc = 0, n, t0, e, d, tk, sw;
	int dv [4] = '{4, 2, 16, 8};
	row_type rows [3] = '{'{4'h1, 16'hfffb, 16'hfffb, 16'h0000},
		'{4'he, 16'd2000, 16'd2000, 16'h03ff}, '{4'hb, 16'd300, 16'd900, 16'h012c}};
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc++;
	analog_core_model u_core (.ain_i(ain), .res_o(core_res_i));
	adc_conversion_timing_control dut (.*);
	task check(input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task conv(input row_type w, input int fr);
		d = dv[w.c[3:2]];
		e = d * ((8 << w.c[1:0]) + 40) + 2;
		@(posedge mclk_i);
		ctrl_i <= w.c;
		ain <= w.a;
		@(posedge mclk_i);
		start_i <= 1'b1;
		n = 0;
		tk = 0;
		sw = 0;
		s = 1'b1;
		// Input moves only once the window is over
		do begin
			@(posedge mclk_i);
			start_i <= 1'b0;
			if (s !== 1'b1)
				ain <= w.b;
			// Freeze lands in the decision phase
			if (fr > 0 && n == e - 10)
				clk_en_i <= 1'b0;
			if (fr > 0 && n == e - 10 + fr)
				clk_en_i <= 1'b1;
			#1;
			s = sample_o;
			sw += (sample_o === 1'b1);
			tk += (bc_tick_o === 1'b1 && (sample_o === 1'b1 || decide_o === 1'b1));
			n++;
		end while (done_o !== 1'b1 && n < 3000);
		check(16'(n), 16'(e + 1 + fr));
		check(16'(sw), 16'(d * (8 << w.c[1:0])));
		check(16'(tk), 16'((8 << w.c[1:0]) + 40));
		check(result_o, w.e);
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		#1;
		check({busy_o, done_o, cal_busy_o, result_o[12:0]}, 16'h2000);
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		#1;
		t0 = cyc;
		conv('{4'h4, 16'd513, 16'd900, 16'h0601}, 0);
		t0 = t0 + n;
		do begin
			@(posedge mclk_i);
			#1;
		end while (cal_busy_o !== 1'b0 && cyc - t0 < 9000);
		check(16'(cyc - t0 > 6650 && cyc - t0 < 6662), 16'h0001);
		foreach (rows[i])
			conv(rows[i], 0);
		// Clock enable low stretches the span by exactly the frozen cycles
		conv('{4'h4, 16'd5, 16'd5, 16'h0005}, 10);
		// Reset in mid-conversion restarts calibration
		@(posedge mclk_i);
		start_i <= 1'b1;
		@(posedge mclk_i);
		start_i <= 1'b0;
		repeat (5) @(posedge mclk_i);
		sys_rst_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		check({busy_o, done_o, cal_busy_o, result_o[12:0]}, 16'h2000);
		@(posedge mclk_i);
		sys_rst_i <= 1'b0;
		conv('{4'h4, 16'd7, 16'd7, 16'h0407}, 0);
		print_verdict;
	end
	initial begin
		#200000;
		mismatches++;
		print_verdict;
	end
endmodule // test_adc_conversion_timing_control
